// file: dv/can_bus_node_model.sv
// bus node model: frees the bus on request, answers one outcome per frame
// assumes: bench picks the outcome before each frame
`timescale 1ns/1ps
`default_nettype none
module can_bus_node_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic tx_start,
	input wire logic bus_en,
	input wire logic [1:0] res_sel,
	output logic bus_available,
	output logic tx_done,
	output logic [1:0] tx_result
);
	logic [2:0] cnt;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt <= 3'h0;
			bus_available <= 1'b0;
			tx_done <= 1'b0;
			tx_result <= 2'h0;
		end else begin
			bus_available <= bus_en && cnt == 3'h0 && !tx_start;
			tx_done <= cnt == 3'h1;
			// stale outcome inverted outside the done pulse
			tx_result <= (cnt == 3'h1) ? res_sel : ~tx_result;
			if (tx_start) begin
				cnt <= 3'h4;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/can_tx_buffer_control_asserts.sv
// checker: port-level timing of the transmit buffer control
// assumes: bound to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_control_asserts (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic bus_available,
	input wire logic tx_done,
	input wire logic [1:0] tx_result,
	input wire logic tx_start,
	input wire logic [can_tx_pkg::BUF_IDX_W-1:0] tx_buffer,
	input wire logic tx_busy,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_START_BUS: assert property (tx_start |-> $past(bus_available) && !$past(tx_busy))
		else $error("start without free bus");
	AST_START_ONE: assert property (tx_start |-> tx_busy ##1 (tx_busy && !tx_start))
		else $error("start not a single pulse");
	AST_BUF_HOLD: assert property (tx_busy && !tx_start |-> $stable(tx_buffer))
		else $error("buffer index moved mid frame");
	AST_BUSY_END: assert property (tx_busy && tx_done |=> tx_busy ##1 !tx_busy)
		else $error("busy end timing wrong");
	AST_IRQ_ERR: assert property (tx_busy && tx_done && tx_result[1] |-> ##[1:2] irq)
		else $error("no irq after send error");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_ACK_BOUND: assert property (wb_cyc_i && wb_stb_i |-> ##[0:2] wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
endmodule
bind can_tx_buffer_control can_tx_buffer_control_asserts u_can_tx_buffer_control_asserts (
	.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .bus_available(bus_available), .tx_done(tx_done),
	.tx_result(tx_result), .tx_start(tx_start), .tx_buffer(tx_buffer),
	.tx_busy(tx_busy), .irq(irq));
`default_nettype wire

// file: dv/can_tx_buffer_control_tb.sv
// testbench: register-level tests of the transmit buffer control
// assumes: bus node model answers each started frame after a few cycles
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_control_tb;
	import can_tx_pkg::*;
	logic ref_clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, bus_en = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, dat_o, q;
	logic ack, bus_available, tx_done, tx_start, tx_busy, irq;
	logic [1:0] tx_result, res_sel = 2'h0;
	logic [BUF_IDX_W-1:0] tx_buffer, last_buf = '0;
	int fails = 0, num_checks = 0, starts = 0;
	can_tx_buffer_control u_can_tx_buffer_control (.ref_clk(ref_clk), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .bus_available(bus_available),
		.tx_done(tx_done), .tx_result(tx_result), .tx_start(tx_start),
		.tx_buffer(tx_buffer), .tx_busy(tx_busy), .irq(irq));
	can_bus_node_model u_can_bus_node_model (.ref_clk(ref_clk), .reset(reset),
		.tx_start(tx_start), .bus_en(bus_en), .res_sel(res_sel),
		.bus_available(bus_available), .tx_done(tx_done), .tx_result(tx_result));
	task automatic end_sim;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", name, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) fails++;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		chk(name, e, q & m);
	endtask
	task automatic frame(input logic [1:0] r, input logic [1:0] b);
		int s0, n;
		s0 = starts;
		n = 0;
		res_sel <= r;
		bus_en <= 1'b1;
		while (starts == s0 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		bus_en <= 1'b0;
		while (tx_busy !== 1'b0 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		// no start seen or busy never dropped counts as a mismatch
		if (starts == s0 || n >= 100) fails++;
		@(posedge ref_clk);
		chk("tx_buffer", {30'h0, b}, {30'h0, last_buf});
	endtask
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		#400000;
		fails++;
		end_sim;
	end
	always @(posedge ref_clk) begin
		if (tx_start === 1'b1) begin
			starts <= starts + 1;
			last_buf <= tx_buffer;
		end
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd_chk("ctrl0", 8'h00, 32'hFFFFFFFF, 32'h0);
		rd_chk("unmapped", 8'hD0, 32'hFFFFFFFF, 32'h0);
		for (int b = 0; b < 3; b++) begin
			for (int r = 1; r < 7; r++) begin
				wb(1'b1, 8'(b * 64 + r * 4), 8'(r == 2 ? 8 : r == 5 ? 1 : 16 * r + b));
			end
			wb(1'b1, 8'(b * 64 + 56), 8'(b > 0 ? 3 : 2));
			wb(1'b1, 8'(b * 64), 8'h0A);
		end
		repeat (5) @(posedge ref_clk);
		chk("starts", 32'h0, 32'(starts));
		rd_chk("ctrl0", 8'h00, 32'hFF, 32'h0A);
		wb(1'b1, 8'h18, 8'hFF);
		rd_chk("data0", 8'h18, 32'hFF, 32'h60);
		rd_chk("prio1", 8'h78, 32'h03, 32'h03);
		frame(2'h1, 2'h2);
		rd_chk("bus_status", 8'hC0, 32'h07, 32'h04);
		rd_chk("ctrl2", 8'h80, 32'h38, 32'h28);
		frame(2'h2, 2'h2);
		rd_chk("ctrl2", 8'h80, 32'h18, 32'h18);
		rd_chk("invalid", 8'hC4, 32'h80, 32'h80);
		chk("irq", 32'h1, {31'h0, irq});
		wb(1'b1, 8'hC4, 8'h80);
		rd_chk("invalid", 8'hC4, 32'h80, 32'h0);
		frame(2'h0, 2'h2);
		rd_chk("ctrl2", 8'h80, 32'h09, 32'h01);
		chk("irq", 32'h1, {31'h0, irq});
		wb(1'b1, 8'h80, 8'h09);
		rd_chk("ctrl2", 8'h80, 32'hFF, 32'h08);
		for (int b = 2; b >= 0; b--) begin
			frame(2'h0, 2'(b));
		end
		rd_chk("ctrl0", 8'h00, 32'hFF, 32'h03);
		wb(1'b1, 8'h18, 8'h77);
		rd_chk("data0", 8'h18, 32'hFF, 32'h77);
		end_sim;
	end
endmodule
`default_nettype wire

// file: hdl/buf_mem_if.sv
// interface: write/read port between control logic and buffer memory
// assumes: one clock, registered read data
`timescale 1ns/1ps
`default_nettype none
interface buf_mem_if;
	import can_tx_pkg::*;
	logic we;
	logic [MEM_AW-1:0] waddr;
	logic [7:0] wdata;
	logic [MEM_AW-1:0] raddr;
	logic [7:0] rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// file: hdl/can_tx_buf_mem.sv
// buffer memory: identifier, length and data bytes of every transmit buffer
// assumes: single clock, one write and one registered read per cycle
`timescale 1ns/1ps
`default_nettype none
module can_tx_buf_mem #(
	parameter int DEPTH = 64
) (
	input wire logic ref_clk,
	buf_mem_if.mem port
);
	import can_tx_pkg::*;
	logic [7:0] store [DEPTH];
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = store[port.raddr];
	end
	always_ff @(posedge ref_clk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
		port.rdata <= next_rdata;
	end
endmodule
`default_nettype wire

// file: hdl/can_tx_buffer_control.sv
// transmit buffer control: wishbone register file, request flags, selection
// assumes: protocol engine reports bus idle, takes frame start and returns one outcome pulse
// Contract
// - host may write a buffer only while its send request flag is clear.
// - setting send request clears aborted, lost-arbitration and error flags.
// - request only marks ready; sending starts when bus is available.
// - on bus available, start highest-priority pending buffer.
// - success clears request, sets sent flag, interrupts if enabled.
// - failure keeps request set and sets exactly one failure flag.
// - error after start sets error flag, invalid flag, and interrupt.
// - lost arbitration sets lost-arbitration flag, request stays pending.
// - writes to a pending buffer's registers are silently ignored; the code still applies a write-one-to-clear of its sent flag.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module can_tx_buffer_control #(
	parameter int NBUF = can_tx_pkg::NUM_BUFFERS
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [can_tx_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bus_available,
	input wire logic tx_done,
	input wire logic [1:0] tx_result,
	output logic tx_start,
	output logic [can_tx_pkg::BUF_IDX_W-1:0] tx_buffer,
	output logic tx_busy,
	output logic irq
);
	import can_tx_pkg::*;
	buf_mem_if mem_bus();
	can_tx_buf_mem #(.DEPTH(1 << MEM_AW)) u_mem (.ref_clk(ref_clk), .port(mem_bus.mem));

	logic [NBUF-1:0] send_request_flag, send_error_flag, lost_arbitration_flag;
	logic [NBUF-1:0] send_aborted_flag, buffer_sent_irq_flag, buffer_sent_irq_enable;
	logic [NBUF-1:0] next_req, next_err, next_larb, next_abt, next_sent, next_ien;
	logic [1:0] prio [NBUF];
	logic [1:0] next_prio [NBUF];
	logic invalid_message_irq_flag, next_invalid;
	tx_state_t state, next_state;
	logic [BUF_IDX_W-1:0] cur, next_cur;
	logic next_start, next_irq, next_ack, next_busy;
	logic [31:0] next_dat;
	logic rd_pending, next_rd_pending;

	logic access, wr, ctrl_wr, glob;
	logic [BUF_IDX_W-1:0] abuf;
	logic [REG_IDX_W-1:0] areg;
	logic [7:0] wbyte;
	logic win_found;
	logic [BUF_IDX_W-1:0] win;
	logic [1:0] win_prio;

	always_comb begin
		access = wb_cyc_i && wb_stb_i && !wb_ack_o;
		wr = access && wb_we_i && wb_sel_i[0];
		abuf = wb_adr_i[ADDR_W-1:6];
		areg = wb_adr_i[5:2];
		glob = (abuf >= BUF_IDX_W'(NBUF));
		wbyte = wb_dat_i[7:0];
		ctrl_wr = wr && !glob && areg == REG_CTRL;
	end

	// highest priority, ties to highest-numbered buffer
	always_comb begin
		win_found = 1'b0;
		win = '0;
		win_prio = '0;
		for (int i = 0; i < NBUF; i++) begin
			if (send_request_flag[i] && (!win_found || prio[i] >= win_prio)) begin
				win_found = 1'b1;
				win = BUF_IDX_W'(i);
				win_prio = prio[i];
			end
		end
	end

	// memory side: bytes of pending buffers are locked
	always_comb begin
		mem_bus.we = wr && !glob && areg >= REG_STD_ID_HIGH && areg < REG_PRIORITY
			&& !send_request_flag[abuf];
		mem_bus.waddr = MEM_AW'({abuf, areg});
		mem_bus.wdata = wbyte;
		mem_bus.raddr = MEM_AW'({abuf, areg});
	end

	always_comb begin
		next_req = send_request_flag;
		next_err = send_error_flag;
		next_larb = lost_arbitration_flag;
		next_abt = send_aborted_flag;
		next_sent = buffer_sent_irq_flag;
		next_ien = buffer_sent_irq_enable;
		next_prio = prio;
		next_invalid = invalid_message_irq_flag;
		next_state = state;
		next_cur = cur;
		next_start = 1'b0;
		// host writes to control and priority of idle buffers
		if (ctrl_wr && !send_request_flag[abuf]) begin
			next_ien[abuf] = wbyte[BIT_SENT_IRQ_ENABLE];
			if (wbyte[BIT_SEND_REQUEST]) begin
				next_req[abuf] = 1'b1;
				next_err[abuf] = 1'b0;
				next_larb[abuf] = 1'b0;
				next_abt[abuf] = 1'b0;
			end
		end
		if (wr && !glob && areg == REG_PRIORITY && !send_request_flag[abuf]) begin
			next_prio[abuf] = wbyte[1:0];
		end
		// write-one-to-clear of the sent flag; hardware set below wins
		if (ctrl_wr && wbyte[BIT_SENT_IRQ_FLAG]) begin
			next_sent[abuf] = 1'b0;
		end
		if (wr && wb_adr_i == ADDR_IRQ_STATUS && wbyte[BIT_INVALID_IRQ]) begin
			next_invalid = 1'b0;
		end
		case (state)
			ST_IDLE: begin
				// wait for idle bus, failed ones re-enter here
				if (bus_available && win_found) begin
					next_cur = win;
					next_start = 1'b1;
					next_state = ST_SEND;
				end
			end
			ST_SEND: begin
				if (tx_done) begin
					next_state = ST_DONE;
					case (tx_result)
						RES_OK: begin
							next_req[cur] = 1'b0;
							next_sent[cur] = 1'b1;
						end
						RES_LOST_ARB: begin
							next_larb[cur] = 1'b1;
						end
						default: begin
							next_err[cur] = 1'b1;
							next_invalid = 1'b1;
						end
					endcase
				end
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
		next_busy = (next_state != ST_IDLE);
		// interrupt from sent flags gated by enables, and invalid flag
		next_irq = |(next_sent & next_ien) || next_invalid;
	end

	// wishbone answer: one wait state for the registered memory read
	always_comb begin
		next_ack = 1'b0;
		next_dat = wb_dat_o;
		next_rd_pending = 1'b0;
		if (access && (wb_we_i || rd_pending || glob || areg == REG_CTRL
			|| areg == REG_PRIORITY)) begin
			next_ack = 1'b1;
			next_dat = UNMAPPED_DATA;
			if (!wb_we_i) begin
				if (wb_adr_i == ADDR_BUS_STATUS) begin
					next_dat = 32'({cur, tx_busy});
				end else if (wb_adr_i == ADDR_IRQ_STATUS) begin
					next_dat[BIT_INVALID_IRQ] = invalid_message_irq_flag;
				end else if (!glob && areg == REG_CTRL) begin
					next_dat[BIT_SEND_ABORTED] = send_aborted_flag[abuf];
					next_dat[BIT_LOST_ARB] = lost_arbitration_flag[abuf];
					next_dat[BIT_SEND_ERROR] = send_error_flag[abuf];
					next_dat[BIT_SEND_REQUEST] = send_request_flag[abuf];
					next_dat[BIT_SENT_IRQ_ENABLE] = buffer_sent_irq_enable[abuf];
					next_dat[BIT_SENT_IRQ_FLAG] = buffer_sent_irq_flag[abuf];
				end else if (!glob && areg == REG_PRIORITY) begin
					next_dat = 32'(prio[abuf]);
				end else if (!glob && areg < REG_PRIORITY) begin
					next_dat = 32'(mem_bus.rdata);
				end
			end
		end else if (access) begin
			next_rd_pending = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			send_request_flag <= '0;
			send_error_flag <= '0;
			lost_arbitration_flag <= '0;
			send_aborted_flag <= '0;
			buffer_sent_irq_flag <= '0;
			buffer_sent_irq_enable <= '0;
			for (int i = 0; i < NBUF; i++) begin
				prio[i] <= '0;
			end
			invalid_message_irq_flag <= 1'b0;
			state <= ST_IDLE;
			cur <= '0;
			tx_start <= 1'b0;
			tx_buffer <= '0;
			tx_busy <= 1'b0;
			irq <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			rd_pending <= 1'b0;
		end else begin
			send_request_flag <= next_req;
			send_error_flag <= next_err;
			lost_arbitration_flag <= next_larb;
			send_aborted_flag <= next_abt;
			buffer_sent_irq_flag <= next_sent;
			buffer_sent_irq_enable <= next_ien;
			prio <= next_prio;
			invalid_message_irq_flag <= next_invalid;
			state <= next_state;
			cur <= next_cur;
			tx_start <= next_start;
			tx_buffer <= next_cur;
			tx_busy <= next_busy;
			irq <= next_irq;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			rd_pending <= next_rd_pending;
		end
	end
endmodule
`default_nettype wire

// file: hdl/can_tx_pkg.sv
// package: register map, field layout and states of the transmit buffer control
// assumes: 32-bit classic wishbone, word-aligned registers
package can_tx_pkg;
	localparam int NUM_BUFFERS = 3;
	localparam int BUF_IDX_W = 2;
	localparam int REGS_PER_BUF = 16;
	localparam int REG_IDX_W = 4;
	localparam int ADDR_W = 8;
	localparam int MEM_AW = 6;
	// register word indices inside one buffer window, byte offset is index * 4 (window stride 0x40)
	localparam logic [ADDR_W-1:0] BUF_STRIDE = 8'h40;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STD_ID_HIGH = 4'h1;
	localparam logic [3:0] REG_STD_ID_LOW = 4'h2;
	localparam logic [3:0] REG_EXT_ID_HIGH = 4'h3;
	localparam logic [3:0] REG_EXT_ID_LOW = 4'h4;
	localparam logic [3:0] REG_LENGTH_CODE = 4'h5;
	localparam logic [3:0] REG_DATA0 = 4'h6;
	localparam logic [3:0] REG_PRIORITY = 4'hE;
	// global registers above the buffer windows
	localparam logic [ADDR_W-1:0] ADDR_BUS_STATUS = 8'hC0;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'hC4;
	// control register fields
	localparam int BIT_SEND_REQUEST = 3;
	localparam int BIT_SEND_ERROR = 4;
	localparam int BIT_LOST_ARB = 5;
	localparam int BIT_SEND_ABORTED = 6;
	localparam int BIT_SENT_IRQ_FLAG = 0;
	localparam int BIT_SENT_IRQ_ENABLE = 1;
	localparam int BIT_INVALID_IRQ = 7;
	localparam int BIT_EXT_ID_ENABLE = 3;
	localparam logic [1:0] PRIO_W1 = 2'h3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DONE} tx_state_t;
	typedef enum logic [1:0] {RES_OK, RES_LOST_ARB, RES_ERROR} tx_result_t;
endpackage
